// [rtl/cmp_defines.svh]
// Offsets, field positions, reset values and counts of the dual comparator event logic
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define CMP_A_CS_IDX 10'h097
`define CMP_B_CS_IDX 10'h098
`define CMP_REF_IDX 10'h099
`define CMP_MISC_IDX 10'h09a

// ****************************************
// Control and status fields
// ****************************************
`define CS_POS_LSB 6
`define CS_CONNECT_BIT 5
`define CS_FLAG_BIT 4
`define CS_ENABLE_BIT 3
`define CS_COND_LSB 0
`define CS_RESET 8'h00

// ****************************************
// Reference control fields (two bits each)
// ****************************************
`define REF_A_SRC_LSB 0
`define REF_B_SRC_LSB 2
`define REF_A_SEL_LSB 4
`define REF_B_SEL_LSB 6
`define REF_RESET 8'h00

// ****************************************
// Miscellaneous register bits
// ****************************************
`define MISC_IRQ_EN_BIT 0
`define MISC_RESULT_LSB 1
`define MISC_FLAG_LSB 3
`define MISC_RESET 1'h0

// ****************************************
// Condition codes and sampling sources
// ****************************************
`define COND_LOW 3'h0
`define COND_HIGH 3'h1
`define COND_TOGGLE 3'h2
`define COND_FALL 3'h4
`define COND_RISE 3'h5
`define SRC_SYSCLK 2'h0
`define SRC_T0 2'h1
`define SRC_T1 2'h2
`define SRC_T2 2'h3

// ****************************************
// Filter counts
// ****************************************
`define PERSIST_SAMPLES 4
`define DEB_OVERFLOWS 2

`endif

// [rtl/cmp_event_unit.sv]
// Per-comparator synchroniser, sampling, edge filter, debouncer and condition match
`timescale 1ns/1ps
`include "cmp_defines.svh"
module cmp_event_unit import cmp_pkg::*; #(
  parameter int PERSIST_SAMPLES = `PERSIST_SAMPLES,
  parameter int DEB_OVERFLOWS = `DEB_OVERFLOWS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Comparator output and timer overflow strobes
  input wire logic cmp_raw,
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  // Configuration
  input wire logic active,
  input wire cond_t cond,
  input wire sel_t sample_src,
  // Results
  output logic result,
  output logic set_pulse
);
  localparam int PW = $clog2(PERSIST_SAMPLES + 1);
  localparam int DW = $clog2(DEB_OVERFLOWS + 1);
  localparam logic [PW-1:0] PERSIST_LAST = PW'(PERSIST_SAMPLES - 1);
  localparam logic [DW-1:0] DEB_LAST = DW'(DEB_OVERFLOWS - 1);

  logic sync1_ff, sync2_ff, acc_ff, exp_ff;
  logic [PW-1:0] persist_ff, nxt_persist;
  logic [DW-1:0] ovf_cnt_ff, nxt_ovf_cnt;
  deb_state_e state_ff, nxt_state;
  logic nxt_exp, deb_set;

  function automatic logic cond_match(input cond_t c, input logic rise, input logic fall,
                                      input logic lvl_hit, input logic val);
    case (c)
      `COND_LOW: cond_match = lvl_hit & ~val;
      `COND_HIGH: cond_match = lvl_hit & val;
      `COND_TOGGLE: cond_match = rise | fall;
      `COND_FALL: cond_match = fall;
      `COND_RISE: cond_match = rise;
      default: cond_match = 1'b0;
    endcase
  endfunction : cond_match

  // ****************************************
  // Sampling
  // ****************************************
  // Result is high when the positive input is above the negative one, once through the two-flop synchroniser and the sample register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= cmp_raw;
      sync2_ff <= sync1_ff;
    end
  end

  wire timer_mode = sample_src != `SRC_SYSCLK;
  wire strobe = (sample_src == `SRC_SYSCLK) ? 1'b1 :
                (sample_src == `SRC_T0) ? t0_ovf :
                (sample_src == `SRC_T1) ? t1_ovf : t2_ovf;
  wire sampling = active & strobe;
  wire differs = sync2_ff != acc_ff;
  wire accept = sampling & differs & (~timer_mode | (persist_ff == PERSIST_LAST));
  wire nxt_acc = accept ? sync2_ff : acc_ff;
  wire rise = accept & sync2_ff;
  wire fall = accept & ~sync2_ff;
  wire is_edge_cond = (cond == `COND_TOGGLE) | (cond == `COND_FALL) | (cond == `COND_RISE);
  wire deb_mode = ~timer_mode & is_edge_cond;
  wire hit = cond_match(cond, rise, fall, sampling, nxt_acc);

  always_comb begin
    nxt_persist = '0;
    if (active && timer_mode) begin
      nxt_persist = persist_ff;
      if (strobe) begin
        nxt_persist = (differs && !accept) ? persist_ff + PW'(1) : '0;
      end
    end
  end

  // ****************************************
  // Debouncer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_exp = exp_ff;
    nxt_ovf_cnt = ovf_cnt_ff;
    deb_set = 1'b0;
    case (state_ff)
      DEB_IDLE: begin
        if (active && deb_mode && hit) begin
          nxt_state = DEB_WAIT;
          nxt_exp = sync2_ff;
          nxt_ovf_cnt = '0;
        end
      end
      DEB_WAIT: begin
        if (!active || !deb_mode) begin
          nxt_state = DEB_IDLE;
        end else if (t1_ovf) begin
          if (ovf_cnt_ff == DEB_LAST) begin
            nxt_state = DEB_IDLE;
            deb_set = sync2_ff == exp_ff;
          end else begin
            nxt_ovf_cnt = ovf_cnt_ff + DW'(1);
          end
        end
      end
      default: nxt_state = DEB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 1'b0;
      persist_ff <= '0;
      state_ff <= DEB_IDLE;
      exp_ff <= 1'b0;
      ovf_cnt_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
      persist_ff <= nxt_persist;
      state_ff <= nxt_state;
      exp_ff <= nxt_exp;
      ovf_cnt_ff <= nxt_ovf_cnt;
    end
  end

  assign result = acc_ff;
  assign set_pulse = active & ((hit & ~deb_mode) | deb_set);

  // ****************************************
  // Checks
  // ****************************************
  inactive_no_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !active |-> !set_pulse) else $error("flag set by inactive comparator");
  unused_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(cond inside {`COND_LOW, `COND_HIGH, `COND_TOGGLE, `COND_FALL, `COND_RISE}) |-> !set_pulse)
    else $error("reserved condition set the flag");
  persist_four_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (timer_mode && accept) |-> (persist_ff == 3)) else $error("edge accepted before four samples");
  deb_two_ovf_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_ff == DEB_IDLE && active && deb_mode && hit && !t1_ovf) ##1
    (active && deb_mode && !t1_ovf) [*2] |-> (state_ff == DEB_WAIT) && !set_pulse)
    else $error("debounce wait ended without two overflows");
  sync_path_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!timer_mode && active) |=> (acc_ff == $past(sync2_ff))) else $error("sample not taken from synchroniser");
endmodule : cmp_event_unit

// [rtl/cmp_pkg.sv]
// Types shared by the dual comparator event logic
package cmp_pkg;
  typedef logic [2:0] cond_t;
  typedef logic [1:0] sel_t;
  typedef enum logic {DEB_IDLE, DEB_WAIT} deb_state_e;
endpackage : cmp_pkg

// [rtl/dual_comparator_event_logic.sv]
// Register file, flags, analog control outputs and common request of the two comparators
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "cmp_defines.svh"
// Contract
// - Result is one when positive exceeds negative
// - Control bit 3 enables each comparator
// - Control bit 5 connects inputs; set before use
// - Condition field selects level, edge or toggle
// - Flags stay set until software clears
// - Both flags share one interrupt request
// - Sample source: system clock or timer overflow
// - Comparators keep working in Idle
// - Power-down forces both comparators off
// - Positive select routes one of four channels
// - Reference select picks negative reference level
// - Source 00 edge modes debounce on Timer 1
// - Wait two Timer 1 overflows, then resample
// - Timer sampling needs four steady samples
// - Connect bit routes or isolates analog pins
module dual_comparator_event_logic import cmp_pkg::*; #(
  parameter int PERSIST_SAMPLES = `PERSIST_SAMPLES,
  parameter int DEB_OVERFLOWS = `DEB_OVERFLOWS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Comparator outputs from the analog cells
  input wire logic cmp_a_raw,
  input wire logic cmp_b_raw,
  // Timer overflow strobes
  input wire logic t0_ovf,
  input wire logic t1_ovf,
  input wire logic t2_ovf,
  // Power state
  input wire logic pd_mode,
  // Analog control
  output logic cmp_a_active,
  output logic cmp_b_active,
  output logic cmp_a_connect,
  output logic cmp_b_connect,
  output logic [1:0] cmp_a_pos_sel,
  output logic [1:0] cmp_b_pos_sel,
  output logic [1:0] cmp_a_ref_sel,
  output logic [1:0] cmp_b_ref_sel,
  // Common request
  output logic cmp_irq
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic sel_t ref_field(input logic [7:0] r, input int lsb);
    ref_field = r[lsb +: 2];
  endfunction : ref_field

  function automatic logic idx_hit(input logic [11:0] a, input logic [9:0] idx);
    idx_hit = a[11:2] == idx;
  endfunction : idx_hit

  // ****************************************
  // APB decode
  // ****************************************
  logic [7:0] cs_ff [2];
  logic [7:0] ref_ff;
  logic cmp_irq_enable_ff;
  logic [1:0] cmp_event_flag_ff, nxt_flag;
  logic [1:0] active_ff;
  logic [31:0] prdata_ff;
  logic [1:0] result;
  logic [1:0] set_pulse;
  logic [1:0] raw;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_a = idx_hit(paddr, `CMP_A_CS_IDX);
  wire hit_b = idx_hit(paddr, `CMP_B_CS_IDX);
  wire hit_ref = idx_hit(paddr, `CMP_REF_IDX);
  wire hit_misc = idx_hit(paddr, `CMP_MISC_IDX);
  wire mapped = hit_a | hit_b | hit_ref | hit_misc;
  wire [1:0] hit_cs = {hit_b, hit_a};

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  wire [7:0] flag_mask = 8'h01 << `CS_FLAG_BIT;
  wire [7:0] cs_a_rd = cs_ff[0] | (cmp_event_flag_ff[0] ? flag_mask : 8'h00);
  wire [7:0] cs_b_rd = cs_ff[1] | (cmp_event_flag_ff[1] ? flag_mask : 8'h00);
  wire [4:0] misc_rd = {cmp_event_flag_ff, result, cmp_irq_enable_ff};
  wire [31:0] rd_mux = hit_a ? {24'h0, cs_a_rd} :
                       hit_b ? {24'h0, cs_b_rd} :
                       hit_ref ? {24'h0, ref_ff} :
                       hit_misc ? {27'h0, misc_rd} : 32'h0;

  // Read data is captured in the setup cycle so it comes from a flip-flop in the access cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end
  assign prdata = prdata_ff;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_ff <= `REF_RESET;
      cmp_irq_enable_ff <= `MISC_RESET;
    end else if (wr) begin
      if (hit_ref) begin
        ref_ff <= pwdata[7:0];
      end
      if (hit_misc) begin
        cmp_irq_enable_ff <= pwdata[`MISC_IRQ_EN_BIT];
      end
    end
  end

  // ****************************************
  // Per-comparator slices
  // ****************************************
  assign raw = {cmp_b_raw, cmp_a_raw};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_cmp
      localparam int SRC_LSB = (i == 0) ? `REF_A_SRC_LSB : `REF_B_SRC_LSB;
      wire wr_cs = wr & hit_cs[i];
      // Writing zero clears the flag; writing one leaves it, so read-modify-write is safe
      wire clr = wr_cs & ~pwdata[`CS_FLAG_BIT];
      wire en = cs_ff[i][`CS_ENABLE_BIT];
      wire conn = cs_ff[i][`CS_CONNECT_BIT];

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cs_ff[i] <= `CS_RESET;
        end else if (wr_cs) begin
          cs_ff[i] <= pwdata[7:0] & ~flag_mask;
        end
      end

      // A set in the same cycle as a clear wins, so no event is lost
      assign nxt_flag[i] = set_pulse[i] | (cmp_event_flag_ff[i] & ~clr);

      // Power-down overrides the enable bit; Idle does not gate anything
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          active_ff[i] <= 1'b0;
          cmp_event_flag_ff[i] <= 1'b0;
        end else begin
          active_ff[i] <= en & ~pd_mode;
          cmp_event_flag_ff[i] <= nxt_flag[i];
        end
      end

      cmp_event_unit #(
        .PERSIST_SAMPLES(PERSIST_SAMPLES),
        .DEB_OVERFLOWS(DEB_OVERFLOWS)
      ) u_unit (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cmp_raw(raw[i]),
        .t0_ovf(t0_ovf),
        .t1_ovf(t1_ovf),
        .t2_ovf(t2_ovf),
        .active(active_ff[i] & conn),
        .cond(cs_ff[i][`CS_COND_LSB +: 3]),
        .sample_src(ref_field(ref_ff, SRC_LSB)),
        .result(result[i]),
        .set_pulse(set_pulse[i])
      );
    end
  endgenerate

  // ****************************************
  // Analog control outputs
  // ****************************************
  assign cmp_a_active = active_ff[0];
  assign cmp_b_active = active_ff[1];
  assign cmp_a_connect = cs_ff[0][`CS_CONNECT_BIT];
  assign cmp_b_connect = cs_ff[1][`CS_CONNECT_BIT];
  assign cmp_a_pos_sel = cs_ff[0][`CS_POS_LSB +: 2];
  assign cmp_b_pos_sel = cs_ff[1][`CS_POS_LSB +: 2];
  assign cmp_a_ref_sel = ref_field(ref_ff, `REF_A_SEL_LSB);
  assign cmp_b_ref_sel = ref_field(ref_ff, `REF_B_SEL_LSB);

  // ****************************************
  // Common request
  // ****************************************
  // Software must keep this off during settling and input changes; nothing here hides it
  assign cmp_irq = cmp_irq_enable_ff & (|cmp_event_flag_ff);

  // ****************************************
  // Checks
  // ****************************************
  irq_after_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (|set_pulse && cmp_irq_enable_ff && !(wr && hit_misc)) |=> cmp_irq)
    else $error("event did not raise the common request");
  flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmp_event_flag_ff[0] && !(wr && hit_a)) |=> cmp_event_flag_ff[0])
    else $error("flag A dropped without software clear");
  set_beats_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (set_pulse[1] && wr && hit_b && !pwdata[`CS_FLAG_BIT]) |=> cmp_event_flag_ff[1])
    else $error("simultaneous clear lost event B");
  powerdown_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pd_mode |=> !cmp_a_active && !cmp_b_active && !set_pulse[0] && !set_pulse[1])
    else $error("comparator active in power-down");
  enable_on_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && hit_a && pwdata[`CS_ENABLE_BIT] && !pd_mode) ##1 !pd_mode |=> cmp_a_active)
    else $error("enable bit did not activate comparator A");
  connect_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && hit_b) |=> cmp_b_connect == $past(pwdata[`CS_CONNECT_BIT]))
    else $error("connect output does not follow write");
  possel_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && hit_a) |=> cmp_a_pos_sel == $past(pwdata[7:6]))
    else $error("positive select does not follow write");
  refsel_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr && hit_ref) |=> (cmp_a_ref_sel == $past(pwdata[5:4])) && (cmp_b_ref_sel == $past(pwdata[7:6])))
    else $error("reference select does not follow write");
  unmapped_err_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (access && !mapped) |-> pslverr && pready) else $error("unmapped access not flagged");
endmodule : dual_comparator_event_logic

// [tb/cmp_analog_model.sv]
// Behavioural model of the two analog comparator cells and the timer overflow strobes
`timescale 1ns/1ps
module cmp_analog_model (
  // Clock
  input wire logic core_clk,
  // Analog control from the block
  input wire logic cmp_a_active,
  input wire logic cmp_b_active,
  input wire logic cmp_a_connect,
  input wire logic cmp_b_connect,
  // Comparator outputs and overflow strobes
  output logic cmp_a_raw,
  output logic cmp_b_raw,
  output logic t0_ovf,
  output logic t1_ovf,
  output logic t2_ovf
);
  int a_pos_mv = 1200;
  int b_pos_mv = 1200;
  int neg_mv = 1300;
  logic noise_ff = 1'b0;

  // ****************************************
  // Comparator cells
  // ****************************************
  // An unpowered or isolated cell gives no meaningful level, so its output chatters
  always @(posedge core_clk) noise_ff <= ~noise_ff;
  assign cmp_a_raw = (cmp_a_active && cmp_a_connect) ? (a_pos_mv > neg_mv) : noise_ff;
  assign cmp_b_raw = (cmp_b_active && cmp_b_connect) ? (b_pos_mv > neg_mv) : noise_ff;

  // ****************************************
  // Stimulus tasks
  // ****************************************
  initial begin
    t0_ovf = 1'b0;
    t1_ovf = 1'b0;
    t2_ovf = 1'b0;
  end

  task automatic set_level(input int which, input logic v);
    if (which == 0) begin
      a_pos_mv <= v ? 1400 : 1200;
    end else begin
      b_pos_mv <= v ? 1400 : 1200;
    end
  endtask : set_level

  // One-cycle overflow strobe of timer 0, 1 or 2
  task automatic pulse(input int idx);
    @(posedge core_clk);
    t0_ovf <= (idx == 0);
    t1_ovf <= (idx == 1);
    t2_ovf <= (idx == 2);
    @(posedge core_clk);
    t0_ovf <= 1'b0;
    t1_ovf <= 1'b0;
    t2_ovf <= 1'b0;
  endtask : pulse
endmodule : cmp_analog_model

// [tb/tb.sv]
// Self-checking testbench of the dual comparator event logic
`timescale 1ns/1ps
`include "cmp_defines.svh"
module tb;
  localparam logic [9:0] ia = `CMP_A_CS_IDX;
  localparam logic [9:0] ib = `CMP_B_CS_IDX;
  localparam logic [9:0] iref = `CMP_REF_IDX;
  localparam logic [9:0] imisc = `CMP_MISC_IDX;
  // Flag expected per condition code after a debounced rising step
  localparam logic [7:0] cond_exp = 8'h27;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, pd_mode, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cmp_a_raw, cmp_b_raw, t0_ovf, t1_ovf, t2_ovf, cmp_irq;
  logic cmp_a_active, cmp_b_active, cmp_a_connect, cmp_b_connect;
  logic [1:0] cmp_a_pos_sel, cmp_b_pos_sel, cmp_a_ref_sel, cmp_b_ref_sel;
  int error_cnt = 0;
  int total_checks = 0;

  dual_comparator_event_logic i_dual_comparator_event_logic (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf),
    .t2_ovf(t2_ovf), .pd_mode(pd_mode), .cmp_a_active(cmp_a_active), .cmp_b_active(cmp_b_active),
    .cmp_a_connect(cmp_a_connect), .cmp_b_connect(cmp_b_connect), .cmp_a_pos_sel(cmp_a_pos_sel),
    .cmp_b_pos_sel(cmp_b_pos_sel), .cmp_a_ref_sel(cmp_a_ref_sel), .cmp_b_ref_sel(cmp_b_ref_sel), .cmp_irq(cmp_irq));

  cmp_analog_model i_cmp_analog_model (.core_clk(core_clk), .cmp_a_active(cmp_a_active),
    .cmp_b_active(cmp_b_active), .cmp_a_connect(cmp_a_connect), .cmp_b_connect(cmp_b_connect),
    .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf), .t2_ovf(t2_ovf));

  // ****************************************
  // Clock, verdict and bus tasks
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt

  // Setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    // Upper bytes carry junk that the block must ignore
    pwdata <= {~{3{wd}}, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, idx, d, x, y);
  endtask : wr

  task automatic flag_is(input logic [9:0] idx, input logic exp);
    logic [31:0] x;
    logic y;
    apb(1'b0, idx, 8'h00, x, y);
    chk("event_flag", {31'h0, exp}, {31'h0, x[4]});
  endtask : flag_is

  // Enable with the input low, let the debouncer swallow the settling event, then clear the flag
  task automatic arm(input logic [9:0] idx, input int which, input logic [7:0] code);
    wr(idx, 8'h20 | code);
    i_cmp_analog_model.set_level(which, 1'b0);
    wt(6);
    wr(idx, 8'h28 | code);
    wt(8);
    i_cmp_analog_model.pulse(1);
    i_cmp_analog_model.pulse(1);
    wr(idx, 8'h28 | code);
  endtask : arm

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    wt(20000);
    error_cnt++;
    wrap_up();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pd_mode = 1'b0;
    rst_n = 1'b0;
    wt(6);
    rst_n <= 1'b1;
    apb(1'b0, ia, 8'h00, r, e);
    chk("ctrl_a_reset", {24'h0, `CS_RESET}, r);
    apb(1'b0, ib, 8'h00, r, e);
    chk("ctrl_b_reset", {24'h0, `CS_RESET}, r);
    apb(1'b0, iref, 8'h00, r, e);
    chk("ref_reset", {24'h0, `REF_RESET}, r);
    apb(1'b0, imisc, 8'h00, r, e);
    chk("misc_reset", 32'h00000000, r);
    apb(1'b0, 10'h09b, 8'h00, r, e);
    chk("unmapped_err", 32'h00000001, {31'h0, e});
    // Level mode, flag sticky, common request
    wr(ia, 8'h29);
    wt(1250);
    wr(ia, 8'h29);
    wr(imisc, 8'h01);
    i_cmp_analog_model.set_level(0, 1'b1);
    wt(10);
    apb(1'b0, ia, 8'h00, r, e);
    chk("ctrl_a_flagged", 32'h00000039, r);
    chk("irq_a", 32'h00000001, {31'h0, cmp_irq});
    apb(1'b0, imisc, 8'h00, r, e);
    chk("misc_a", 32'h0000000b, r);
    i_cmp_analog_model.set_level(0, 1'b0);
    wt(10);
    flag_is(ia, 1'b1);
    wr(ia, 8'h29);
    wt(1);
    flag_is(ia, 1'b0);
    chk("irq_clear", 32'h00000000, {31'h0, cmp_irq});
    // Enabled but disconnected: noisy output must never flag
    wr(ia, 8'h09);
    wt(20);
    flag_is(ia, 1'b0);
    chk("connect_off", 32'h00000000, {31'h0, cmp_a_connect});
    // Every condition code against a debounced rising step
    for (int c = 0; c < 8; c++) begin
      arm(ia, 0, 8'(c));
      i_cmp_analog_model.set_level(0, 1'b1);
      wt(8);
      i_cmp_analog_model.pulse(1);
      i_cmp_analog_model.pulse(1);
      wt(8);
      flag_is(ia, cond_exp[c]);
    end
    wr(ia, 8'h20);
    // Debounce on comparator B: accepted step, then a glitch
    arm(ib, 1, 8'h05);
    i_cmp_analog_model.set_level(1, 1'b1);
    wt(8);
    i_cmp_analog_model.pulse(1);
    i_cmp_analog_model.pulse(1);
    wt(8);
    flag_is(ib, 1'b1);
    chk("irq_b", 32'h00000001, {31'h0, cmp_irq});
    wr(imisc, 8'h00);
    wt(1);
    chk("irq_masked", 32'h00000000, {31'h0, cmp_irq});
    i_cmp_analog_model.set_level(1, 1'b0);
    wt(8);
    i_cmp_analog_model.pulse(1);
    i_cmp_analog_model.pulse(1);
    wr(ib, 8'h2d);
    i_cmp_analog_model.set_level(1, 1'b1);
    wt(8);
    i_cmp_analog_model.pulse(1);
    i_cmp_analog_model.set_level(1, 1'b0);
    wt(8);
    i_cmp_analog_model.pulse(1);
    wt(8);
    flag_is(ib, 1'b0);
    wr(ib, 8'h25);
    // Timer sampling sources need four steady samples
    for (int s = 1; s < 4; s++) begin
      wr(ia, 8'h25);
      wr(iref, 8'(s));
      i_cmp_analog_model.set_level(0, 1'b0);
      wt(6);
      wr(ia, 8'h2d);
      wt(8);
      // Let the low level be accepted first, so the held high result really changes
      repeat (4) i_cmp_analog_model.pulse(s - 1);
      i_cmp_analog_model.set_level(0, 1'b1);
      wt(8);
      repeat (3) i_cmp_analog_model.pulse(s - 1);
      wt(4);
      flag_is(ia, 1'b0);
      i_cmp_analog_model.pulse(s - 1);
      wt(6);
      flag_is(ia, 1'b1);
    end
    // Input and reference change with the disconnect sequence, then power-down
    wr(ia, 8'h00);
    wr(ia, 8'h80);
    wr(iref, 8'he0);
    wr(ia, 8'hab);
    wt(2);
    chk("active_a", 32'h00000001, {31'h0, cmp_a_active});
    chk("connect_a", 32'h00000001, {31'h0, cmp_a_connect});
    chk("pos_sel_a", 32'h00000002, {30'h0, cmp_a_pos_sel});
    chk("ref_sel_a", 32'h00000002, {30'h0, cmp_a_ref_sel});
    chk("ref_sel_b", 32'h00000003, {30'h0, cmp_b_ref_sel});
    pd_mode <= 1'b1;
    i_cmp_analog_model.set_level(1, 1'b1);
    wr(ib, 8'h69);
    wt(10);
    chk("pd_active_a", 32'h00000000, {31'h0, cmp_a_active});
    chk("pos_sel_b", 32'h00000001, {30'h0, cmp_b_pos_sel});
    flag_is(ib, 1'b0);
    pd_mode <= 1'b0;
    wt(10);
    chk("awake_active_b", 32'h00000001, {31'h0, cmp_b_active});
    flag_is(ib, 1'b1);
    // Clear while the level still matches: the set in the same cycle wins
    wr(ib, 8'h69);
    flag_is(ib, 1'b1);
    wrap_up();
  end
endmodule : tb
